// ==== design/possens_pkg.sv ====
package possens_pkg;
  localparam logic [15:0] ADDR_INTERVAL   = 16'h000b;
  localparam logic [15:0] ADDR_POWER_MODE = 16'h000e;
  localparam logic [15:0] ADDR_RESULT     = 16'h0100;
  localparam logic [15:0] ADDR_CHECKSUM   = 16'h0108;
  localparam logic [15:0] ADDR_TEMP       = 16'h0110;
  localparam logic [15:0] ADDR_POSITION   = 16'h0122;
  localparam int          DIR_BIT         = 15;
  localparam int          FRAME_BITS      = 32;
  localparam int          WORD_BITS       = 16;
  localparam int          CLOCK_HZ        = 10000000;
  localparam int          RESET_MIN_NS    = 1800;
  localparam int          RESET_MAX_NS    = 7100;
  localparam int          RESET_CYCLES    = (RESET_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int          WAKE_MAX_US     = 200;
  localparam int          WAKE_CYCLES     = WAKE_MAX_US * (CLOCK_HZ / 1000000) / 2;
  localparam int          INTERVAL0_US    = 1000;
  localparam int          INTERVAL1_US    = 2000;
  localparam int          INTERVAL0_CYCLES = INTERVAL0_US * (CLOCK_HZ / 1000000);
  localparam int          INTERVAL1_CYCLES = INTERVAL1_US * (CLOCK_HZ / 1000000);
  localparam int          SCK_MAX_HZ      = 1000000;
  localparam int          SCK_HALF_CYCLES = CLOCK_HZ / SCK_MAX_HZ / 2;
  localparam int          MODE_SINGLE_BIT = 0;
  localparam int          INTERVAL_SEL_BIT = 0;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [15:0] CTRL_GO         = 16'h0001;
  localparam logic [15:0] STAT_BUSY       = 16'h0001;
  localparam logic [15:0] STAT_READY      = 16'h0002;
  localparam logic [15:0] STAT_RESET      = 16'h0004;
  localparam logic [11:0] APB_CTRL        = 12'h000;
  localparam logic [11:0] APB_ADDR        = 12'h004;
  localparam logic [11:0] APB_WDATA       = 12'h008;
  localparam logic [11:0] APB_RDATA       = 12'h00c;
  localparam logic [11:0] APB_STATUS      = 12'h010;
  localparam logic [11:0] APB_CSMODE      = 12'h014;
endpackage : possens_pkg

// ==== design/sensor_link_if.sv ====
`timescale 1ns/1ps
interface sensor_link_if;
  logic sck;
  logic mosi;
  logic cs_n;
  logic miso;
  logic miso_oe;
  logic ready;
  logic reset_pin_in;
  logic reset_dev_out;
  logic reset_dev_oe;
  logic reset_host_out;
  logic reset_host_oe;
  modport sensor (input sck, mosi, cs_n, reset_pin_in,
                  output miso, miso_oe, ready, reset_dev_out, reset_dev_oe);
  modport host (input miso, miso_oe, ready, reset_pin_in,
                output sck, mosi, cs_n, reset_host_out, reset_host_oe);
endinterface : sensor_link_if

// ==== design/position_sensor.sv ====
`timescale 1ns/1ps
// Contract
// - Chip select low enables sensor serial participation.
// - Chip select may stay low across commands.
// - Both directions transfer on rising SCK.
// - Without chip select, frames found by counting.
// - Host uses one chip select per sensor.
// - Host checks alignment by checksum or readback.
// - Reading result or position clears ready.
// - Continuous mode measures, updates, raises ready.
// - Single-loop mode enters standby after measuring.
// - Mode chosen by power mode control register.
// - Single-loop raises ready before standby.
// - Reset pin outputs internal power-on reset.
// - Reset pin driven low applies internal reset.
// - Host waits for ready after power-up.
// - Internal reset pulse 1.8 to 7.1 microseconds.
// - Die temperature signed, zero at 25 degrees.
// - Sample interval chosen by interval register.
// - Host serial clock at most 1 MHz.
// - Frame is 16-bit address, 16-bit data.
// - Address MSB zero reads, one writes.
// - Read data shifts out in following 16 cycles.
// - Checksum XORs every read, readable at 0108h.
module position_sensor
  import possens_pkg::*;
#(
  parameter int INTERVAL0 = INTERVAL0_CYCLES,
  parameter int INTERVAL1 = INTERVAL1_CYCLES,
  parameter int WAKE      = WAKE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  sensor_link_if.sensor    link,
  input  wire logic [15:0] position_in,
  input  wire logic [15:0] temperature_in,
  input  wire logic        use_chip_select
);
  if (INTERVAL0 < 2 || INTERVAL1 < 2 || WAKE < 1) begin : bad_counts
    $error("position_sensor: bad counts");
  end

  typedef enum {ST_RESET, ST_MEASURE, ST_STANDBY, ST_WAKE} seq_state_t;

  logic [1:0]  sck_sync;
  logic [1:0]  mosi_sync;
  logic [1:0]  cs_sync;
  logic [1:0]  rst_sync;
  logic [1:0]  drv_sync;
  logic        sck_last;
  logic [4:0]  bit_count;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [15:0] addr_word;
  logic        in_data;
  logic [15:0] interval_reg;
  logic [15:0] mode_reg;
  logic [15:0] result_reg;
  logic [15:0] temp_reg;
  logic [15:0] position_reg;
  logic [15:0] checksum;
  logic        ready;
  logic        por_active;
  logic [7:0]  por_count;
  logic [31:0] timer;
  seq_state_t  state;

  wire cs_low     = !use_chip_select || !cs_sync[1];
  wire pin_pulled = !rst_sync[1] && !drv_sync[1];
  wire enter_reset = pin_pulled && !por_active;
  wire sck_rise   = sck_sync[1] && !sck_last && cs_low;
  wire [15:0] next_shift = {shift_in[14:0], mosi_sync[1]};
  wire addr_done  = sck_rise && !in_data && bit_count == 5'(WORD_BITS - 1);
  wire data_done  = sck_rise && in_data && bit_count == 5'(WORD_BITS - 1);
  wire is_write   = addr_word[DIR_BIT];
  wire [15:0] read_addr = {1'b0, next_shift[14:0]};
  wire rd_result  = addr_done && !next_shift[DIR_BIT] && read_addr == ADDR_RESULT;
  wire rd_pos     = addr_done && !next_shift[DIR_BIT] && read_addr == ADDR_POSITION;
  wire single     = mode_reg[MODE_SINGLE_BIT];
  wire [31:0] interval = interval_reg[INTERVAL_SEL_BIT] ? INTERVAL1 : INTERVAL0;
  wire meas_done  = state == ST_MEASURE && timer >= interval - 32'd1;
  logic [15:0] read_value;

  always_comb begin
    case (read_addr)
      ADDR_INTERVAL:   read_value = interval_reg;
      ADDR_POWER_MODE: read_value = mode_reg;
      ADDR_RESULT:     read_value = result_reg;
      ADDR_CHECKSUM:   read_value = checksum;
      ADDR_TEMP:       read_value = temp_reg;
      ADDR_POSITION:   read_value = position_reg;
      default:         read_value = WORD_ZERO;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_sync  <= 2'b00;
      mosi_sync <= 2'b00;
      cs_sync   <= 2'b11;
      rst_sync  <= 2'b11;
      drv_sync  <= 2'b11;
      sck_last  <= 1'b0;
    end else if (enable) begin
      sck_sync  <= {sck_sync[0], link.sck};
      mosi_sync <= {mosi_sync[0], link.mosi};
      cs_sync   <= {cs_sync[0], link.cs_n};
      rst_sync  <= {rst_sync[0], link.reset_pin_in};
      // Own drive of the reset pin, delayed like the pin so that it can be masked.
      drv_sync  <= {drv_sync[0], por_active};
      sck_last  <= sck_sync[1];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      por_active <= 1'b1;
      por_count  <= 8'h00;
    end else if (enable) begin
      if (enter_reset) begin
        por_active <= 1'b1;
        por_count  <= 8'h00;
      end else if (por_active && por_count < 8'(RESET_CYCLES - 1)) begin
        por_count <= por_count + 8'h01;
      end else if (por_active) begin
        por_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_count <= 5'h00;
      in_data   <= 1'b0;
      shift_in  <= WORD_ZERO;
      shift_out <= WORD_ZERO;
      addr_word <= WORD_ZERO;
      checksum  <= WORD_ZERO;
      interval_reg <= WORD_ZERO;
      mode_reg  <= WORD_ZERO;
    end else if (enable) begin
      if (por_active || (use_chip_select && cs_sync[1])) begin
        bit_count <= 5'h00;
        in_data   <= 1'b0;
        if (por_active) begin
          checksum <= WORD_ZERO;
        end
      end else if (sck_rise) begin
        shift_in  <= next_shift;
        shift_out <= {shift_out[14:0], 1'b0};
        bit_count <= (bit_count == 5'(WORD_BITS - 1)) ? 5'h00 : bit_count + 5'h01;
        if (addr_done) begin
          in_data   <= 1'b1;
          addr_word <= next_shift;
          shift_out <= read_value;
          if (!next_shift[DIR_BIT]) begin
            checksum <= checksum ^ read_value;
          end
        end else if (data_done) begin
          in_data   <= 1'b0;
          shift_out <= addr_word;
          if (is_write && {1'b0, addr_word[14:0]} == ADDR_INTERVAL) begin
            interval_reg <= next_shift;
          end
          if (is_write && {1'b0, addr_word[14:0]} == ADDR_POWER_MODE) begin
            mode_reg <= next_shift;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state        <= ST_RESET;
      timer        <= 32'h0;
      ready        <= 1'b0;
      result_reg   <= WORD_ZERO;
      temp_reg     <= WORD_ZERO;
      position_reg <= WORD_ZERO;
    end else if (enable) begin
      if (por_active || enter_reset) begin
        state <= ST_RESET;
        timer <= 32'h0;
        ready <= 1'b0;
      end else begin
        if (meas_done) begin
          ready <= 1'b1;
        end else if (rd_result || rd_pos) begin
          ready <= 1'b0;
        end
        case (state)
          ST_RESET: begin
            state <= ST_MEASURE;
            timer <= 32'h0;
          end
          ST_MEASURE: begin
            timer <= timer + 32'h1;
            if (meas_done) begin
              result_reg   <= position_in;
              position_reg <= position_in;
              temp_reg     <= temperature_in;
              timer        <= 32'h0;
              state        <= single ? ST_STANDBY : ST_MEASURE;
            end
          end
          ST_STANDBY: begin
            timer <= 32'h0;
            if (!single) begin
              state <= ST_WAKE;
            end
          end
          ST_WAKE: begin
            timer <= timer + 32'h1;
            if (timer >= WAKE - 1) begin
              state <= ST_MEASURE;
              timer <= 32'h0;
            end
          end
          default: state <= ST_RESET;
        endcase
      end
    end
  end

  assign link.miso          = shift_out[WORD_BITS - 1];
  assign link.miso_oe       = use_chip_select ? !cs_sync[1] : 1'b1;
  assign link.ready         = ready;
  assign link.reset_dev_out = 1'b0;
  assign link.reset_dev_oe  = por_active;
endmodule : position_sensor

// ==== design/sensor_host.sv ====
`timescale 1ns/1ps
module sensor_host
  import possens_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sensor_link_if.host      link
);
  if (HALF < 5 || HALF > 256) begin : bad_half
    $error("sensor_host: link clock divider out of range");
  end

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_DONE} host_state_t;

  logic [1:0]  miso_sync;
  logic [1:0]  ready_sync;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        cs_mode;
  logic        reset_req;
  logic [31:0] tx;
  logic [31:0] rx;
  logic [5:0]  bits;
  logic [7:0]  phase;
  logic        sck;
  host_state_t state;

  wire access = psel && penable;
  wire wr     = access && pwrite;
  wire go     = wr && paddr == APB_CTRL && pwdata[0] && state == H_IDLE;
  wire busy   = state != H_IDLE;
  wire [31:0] status = {29'h0, reset_req, ready_sync[1], busy};

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    case (paddr)
      APB_ADDR:   prdata = {16'h0, addr_reg};
      APB_WDATA:  prdata = {16'h0, wdata_reg};
      APB_RDATA:  prdata = {16'h0, rdata_reg};
      APB_STATUS: prdata = status;
      APB_CSMODE: prdata = {31'h0, cs_mode};
      default:    prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miso_sync  <= 2'b00;
      ready_sync <= 2'b00;
    end else if (enable) begin
      miso_sync  <= {miso_sync[0], link.miso};
      ready_sync <= {ready_sync[0], link.ready};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_reg  <= WORD_ZERO;
      wdata_reg <= WORD_ZERO;
      cs_mode   <= 1'b1;
      reset_req <= 1'b0;
    end else if (enable && wr) begin
      if (paddr == APB_ADDR)   addr_reg  <= pwdata[15:0];
      if (paddr == APB_WDATA)  wdata_reg <= pwdata[15:0];
      if (paddr == APB_CSMODE) cs_mode   <= pwdata[0];
      if (paddr == APB_STATUS) reset_req <= pwdata[2];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state     <= H_IDLE;
      tx        <= 32'h0;
      rx        <= 32'h0;
      bits      <= 6'h00;
      phase     <= 8'h00;
      sck       <= 1'b0;
      rdata_reg <= WORD_ZERO;
    end else if (enable) begin
      case (state)
        H_IDLE: begin
          sck <= 1'b0;
          if (go) begin
            tx    <= {addr_reg, wdata_reg};
            bits  <= 6'h00;
            phase <= 8'h00;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          phase <= phase + 8'h01;
          if (phase == 8'(HALF - 1)) begin
            phase <= 8'h00;
            sck   <= 1'b1;
            rx    <= {rx[30:0], miso_sync[1]};
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          phase <= phase + 8'h01;
          if (phase == 8'(HALF - 1)) begin
            phase <= 8'h00;
            sck   <= 1'b0;
            tx    <= {tx[30:0], 1'b0};
            bits  <= bits + 6'h01;
            state <= (bits == 6'(FRAME_BITS - 1)) ? H_DONE : H_LOW;
          end
        end
        H_DONE: begin
          rdata_reg <= rx[15:0];
          state     <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.sck            = sck;
  assign link.mosi           = tx[FRAME_BITS - 1];
  assign link.cs_n           = !(cs_mode && busy);
  assign link.reset_host_out = 1'b0;
  assign link.reset_host_oe  = reset_req;
endmodule : sensor_host

// ==== bench/link_sva.sv ====
`timescale 1ns/1ps
module link_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic ready,
  input wire logic reset_pin_in,
  input wire logic reset_dev_out,
  input wire logic reset_dev_oe,
  input wire logic use_cs
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic [7:0] hold_cnt;
  logic [7:0] rst_cnt;
  // Cycles since the link clock last moved, and cycles spent in internal reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= 8'h00;
      rst_cnt  <= 8'h00;
    end else begin
      hold_cnt <= $changed(sck) ? 8'h00 : hold_cnt + {7'h00, hold_cnt != 8'hff};
      rst_cnt  <= reset_dev_oe ? rst_cnt + {7'h00, rst_cnt != 8'hff} : 8'h00;
    end
  end
  sequence sck_rise;
    $rose(sck);
  endsequence
  sequence pin_pulled;
    $fell(reset_pin_in) && !reset_dev_oe;
  endsequence
  a_sck_rate: assert property ($changed(sck) |-> hold_cnt >= 8'h04)
    else $error("link clock half period too short");
  a_mosi_setup: assert property (sck_rise |-> $stable(mosi))
    else $error("mosi moved at a rising link clock edge");
  a_sck_selected: assert property (sck_rise |-> !cs_n || !use_cs)
    else $error("link clock rose while not selected");
  a_miso_released: assert property ((cs_n && use_cs) [*4] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_miso_driven: assert property (!cs_n [*4] |-> miso_oe)
    else $error("miso not driven while selected");
  a_reset_low: assert property (reset_dev_oe |-> !reset_dev_out && !ready)
    else $error("reset pin or ready wrong during internal reset");
  a_reset_width: assert property ($fell(reset_dev_oe) |-> rst_cnt >= 8'h12 && rst_cnt <= 8'h47)
    else $error("internal reset pulse length out of range");
  a_pin_resets: assert property (pin_pulled |-> ##[1:200] reset_dev_oe)
    else $error("reset pin low did not start internal reset");
endmodule : link_sva

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module testbench;
  import possens_pkg::*;
  localparam int          IV0 = 1000;
  localparam int          IV1 = 2000;
  localparam logic [15:0] WR  = 16'h8000;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [15:0] position_in = 16'h1234;
  logic [15:0] temperature_in = 16'hfe0c;
  logic        ready_q = 1'b0;
  logic        oe_q = 1'b0;
  logic        use_cs = 1'b1;
  logic [15:0] rx;
  logic [31:0] s;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          rise_cnt = 0;
  int          rise_at = 0;
  int          rst_seen = 0;
  int          cyc = 0;
  int          t1;
  int          t2;
  int          n;
  int          hi;
  sensor_link_if link();
  assign link.reset_pin_in = !(link.reset_dev_oe & !link.reset_dev_out)
                           & !(link.reset_host_oe & !link.reset_host_out);
  position_sensor #(.INTERVAL0(IV0), .INTERVAL1(IV1), .WAKE(5)) position_sensor_i (
    .clock(clock), .resetn(resetn), .enable(1'b1), .link(link), .position_in(position_in),
    .temperature_in(temperature_in), .use_chip_select(use_cs));
  sensor_host sensor_host_i (
    .clock(clock), .resetn(resetn), .enable(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .link(link));
  link_sva link_sva_i (
    .clock(clock), .resetn(resetn), .sck(link.sck), .mosi(link.mosi), .cs_n(link.cs_n),
    .miso_oe(link.miso_oe), .ready(link.ready), .reset_pin_in(link.reset_pin_in),
    .reset_dev_out(link.reset_dev_out), .reset_dev_oe(link.reset_dev_oe),
    .use_cs(use_cs));
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ready_q <= link.ready;
    oe_q <= link.reset_dev_oe;
    if (link.ready === 1'b1 && ready_q !== 1'b1) begin
      rise_cnt <= rise_cnt + 1;
      rise_at <= cyc;
    end
    if (link.reset_dev_oe === 1'b1 && oe_q !== 1'b1) rst_seen <= rst_seen + 1;
  end
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task timeout;
    error_cnt++;
    $display("unexpected wait expired");
    end_of_test;
  endtask : timeout
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) timeout;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    apb(1'b1, a, {16'h0000, d}, q);
  endtask : wr
  // One full link frame through the host: address, data, start, poll, fetch.
  task automatic frame(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    int          k;
    logic [31:0] v;
    wr(APB_ADDR, a);
    wr(APB_WDATA, d);
    wr(APB_CTRL, CTRL_GO);
    k = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0, v);
      k++;
    end while ((v[15:0] & STAT_BUSY) !== WORD_ZERO && k < 400);
    if (k >= 400) timeout;
    apb(1'b0, APB_RDATA, 32'h0, v);
    q = v[15:0];
  endtask : frame
  task automatic wait_ready(output int t);
    int k;
    k = 0;
    while (link.ready !== 1'b1 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) timeout;
    @(negedge clock);
    t = rise_at;
  endtask : wait_ready
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (5) @(posedge clock);
    `CHECK("reset_drive", 1'b1, link.reset_dev_oe)
    `CHECK("ready_in_reset", 1'b0, link.ready)
    wr(APB_CSMODE, 16'h0001);
    wait_ready(t1);
    apb(1'b0, APB_STATUS, 32'h0, s);
    `CHECK("status_ready", STAT_READY, s[15:0] & STAT_READY)
    frame(ADDR_POSITION, WORD_ZERO, rx);
    `CHECK("position", position_in, rx)
    `CHECK("ready_clear_pos", 1'b0, link.ready)
    frame(ADDR_TEMP, WORD_ZERO, rx);
    `CHECK("temperature", temperature_in, rx)
    frame(ADDR_CHECKSUM, WORD_ZERO, rx);
    `CHECK("checksum", position_in ^ temperature_in, rx)
    for (int i = 0; i < 2; i++) begin
      frame(ADDR_INTERVAL | WR, i[15:0], rx);
      frame(ADDR_INTERVAL, WORD_ZERO, rx);
      `CHECK("interval_sel", i[15:0], rx)
      frame(ADDR_RESULT, WORD_ZERO, rx);
      wait_ready(t1);
      frame(ADDR_RESULT, WORD_ZERO, rx);
      `CHECK("result", position_in, rx)
      `CHECK("ready_clear_res", 1'b0, link.ready)
      wait_ready(t2);
      n = i ? IV1 : IV0;
      hi = i ? IV1 * 215 / 200 : IV0 * 108 / 100;
      `CHECK("interval_len", 1'b1, t2 - t1 >= n * 9 / 10 && t2 - t1 <= hi)
    end
    frame(ADDR_RESULT, WORD_ZERO, rx);
    frame(ADDR_POWER_MODE | WR, 16'h0001, rx);
    wait_ready(t1);
    frame(ADDR_RESULT, WORD_ZERO, rx);
    frame(ADDR_POWER_MODE, WORD_ZERO, rx);
    `CHECK("mode", 16'h0001, rx)
    n = rise_cnt;
    repeat (3 * IV1) @(posedge clock);
    `CHECK("standby", n, rise_cnt)
    frame(ADDR_POWER_MODE | WR, WORD_ZERO, rx);
    t2 = cyc;
    wait_ready(t1);
    `CHECK("wake", 1'b1, t1 - t2 <= 5 + IV1 * 215 / 200)
    n = rst_seen;
    wr(APB_STATUS, STAT_RESET);
    wr(APB_STATUS, WORD_ZERO);
    repeat (100) @(posedge clock);
    `CHECK("pin_reset", n + 1, rst_seen)
    wait_ready(t1);
    wr(APB_CSMODE, WORD_ZERO);
    use_cs <= 1'b0;
    frame(ADDR_TEMP, WORD_ZERO, rx);
    `CHECK("temperature_nocs", temperature_in, rx)
    frame(ADDR_POSITION, WORD_ZERO, rx);
    `CHECK("position_nocs", position_in, rx)
    end_of_test;
  end
endmodule : testbench
